// >>> core/ccfp_pkg.sv
/*
  Shared constants, encodings and carrier types for the cache flush and
  prefetch-cache control block.
  Assumes a 32-bit APB register bus and a single processor clock domain.
*/
package ccfp_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_DISPATCH_CTRL = 12'h000; // Prefetch enables
  localparam logic [11:0] OFS_MAINT_PA      = 12'h004; // Maintenance physical address
  localparam logic [11:0] OFS_MAINT_CMD     = 12'h008; // Maintenance command
  localparam logic [11:0] OFS_STATUS        = 12'h00C; // Block state

  // Control field positions
  localparam int BIT_PCACHE_EN = 0; // Prefetch-cache enable
  localparam int BIT_HW_PF_EN  = 1; // Hardware prefetch enable
  localparam int BIT_SW_PF_EN  = 2; // Software prefetch enable

  // Status field positions
  localparam int BIT_ST_BUSY   = 0; // Sequencer not idle
  localparam int BIT_ST_UNSUP  = 1; // All three enables set
  localparam int BIT_ST_UNDEF  = 2; // Sticky, phys-use-L2 access hit D-cache
  localparam int BIT_ST_CBPEND = 3; // Sequencer not idle (cb_ready low), same as busy

  // Reset values
  localparam logic [2:0] RST_DISPATCH = 3'h0; // All prefetching off

  // Geometry of the data cache and the commit block
  localparam int DC_WAYS      = 4;  // Associativity
  localparam int DC_LINE_B    = 32; // Line size in bytes
  localparam int DC_VA_IDX    = 13; // Virtual index bit
  localparam int DC_PA_IDX_HI = 12; // Top physical index bit
  localparam int DC_PA_IDX_LO = 5;  // Bottom physical index bit
  localparam int DC_IDX_W     = DC_PA_IDX_HI - DC_PA_IDX_LO + 2; // Index width
  localparam int BLK_BYTES    = 64; // Commit block size
  localparam int BLK_WORDS    = BLK_BYTES / 4; // 32-bit beats per block
  localparam int BLK_OFS_W    = 6;  // Byte offset bits in a block

  // Maintenance operations
  typedef enum logic [1:0] {
    MCMD_DC_PA_INV  = 2'h0, // D-cache invalidate by physical address
    MCMD_L2_FLUSH   = 2'h1, // L2 and W-cache flush with writeback
    MCMD_L2_DIAG    = 2'h2, // L2 diagnostic tag invalidate, no writeback
    MCMD_INV_ALL    = 2'h3  // Invalidate block in every cache
  } ccfp_op_t;

  // Sequencer states
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01, // Waiting
    ST_DINV  = 7'h02, // Two D-cache index invalidates
    ST_L2FL  = 7'h04, // L2 plus W-cache flush with writeback
    ST_L2DG  = 7'h08, // L2 diagnostic invalidate
    ST_CBRD  = 7'h10, // Commit buffer first read
    ST_CBWR  = 7'h20, // Commit data to memory
    ST_CBINV = 7'h40  // Commit invalidate in all caches
  } ccfp_state_t;

  // Access from the load/store pipeline
  typedef struct packed {
    logic        valid;       // Access present
    logic        phys_cacheable_bit; // Physically cacheable
    logic        virt_cacheable_bit; // Virtually cacheable
    logic        phys_use_l2; // Physical-use-L2 address space
    logic        fp_load;     // Floating-point load
    logic        block_load;  // Block load
    logic        sw_prefetch; // Software prefetch instruction
    logic        dc_hit;      // D-cache tag hit for this access
  } ccfp_acc_t;

  // Per-access cache decisions
  typedef struct packed {
    logic        valid;       // Decision present
    logic        dc_use;      // Look up and fill D-cache
    logic        dc_bypass;   // Bypass D-cache, stale hit possible
    logic        l2_alloc;    // Allowed to allocate in L2
    logic        pc_lookup;   // Look up prefetch cache
    logic        pc_fp_fill;  // Install 32-byte FP miss data
    logic        sw_pf_go;    // Software prefetch takes effect
    logic        hw_pf_ok;    // Access may trigger hardware prefetch
  } ccfp_dec_t;

  // Maintenance request to cache arrays
  typedef struct packed {
    ccfp_op_t             op;       // Operation
    logic [31:0]          pa;       // Physical address
    logic [DC_IDX_W-1:0]  dc_idx;   // D-cache set index
    logic [DC_WAYS-1:0]   way_mask; // Ways to update
    logic                 wb;       // Write modified data back first
    logic                 wc_too;   // Flush matching W-cache block too
  } ccfp_maint_t;

  // L2 fill displacing a victim
  typedef struct packed {
    logic        valid;        // Fill event
    logic        victim_dirty; // Victim holds modified data
    logic [31:0] victim_pa;    // Victim physical address
  } ccfp_fill_t;

endpackage

// >>> core/ccfp_blk_buf.sv
/*
  Commit block data buffer: one 64-byte block as 32-bit words.
  Assumes one write port from the FP register side and a registered read.
*/
`timescale 1ns/1ps
module ccfp_blk_buf #(
  parameter int WORDS = 16, // Words held
  parameter int AW    = 4   // Address width
) (
  // Clock
  input  wire logic          pclk,
  // Write side
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [31:0]   wdata,
  // Read side
  input  wire logic [AW-1:0] raddr,
  output logic [31:0]        rdata_r
);

  // Storage, no reset needed for data
  logic [31:0] mem [WORDS];

  // Refuse a geometry the address cannot reach
  if ((1 << AW) < WORDS) begin : g_chk
    $error("ccfp_blk_buf address too narrow");
  end

  // Write port
  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read port
  always_ff @(posedge pclk) begin
    rdata_r <= mem[raddr];
  end

endmodule

// >>> core/ccfp_ctrl.sv
/*
  Cache flush sequencer and prefetch-cache gating with an APB register file.
  Assumes pipeline, cache arrays and memory port all run on pclk.
*/
// Design decisions made here: the APB slave port and the register addresses.
// Behaviour
// - Write-through flush invalidates; L2 flush writes back
// - PA invalidate space clears matching D-cache lines
// - L2 block flush also flushes W-cache block
// - Index uses VA bit 13; update all ways
// - Commit store writes 64 bytes, invalidates everywhere
// - Barrier waits for outstanding commit flushes
// - Displaced modified entries get written back
// - Diagnostic L2 invalidate skips writeback
// - Decode the two cacheability bits
// - Physical-only access may see stale D-cache
// - Phys-use-L2 D-cache hit is undefined
// - Block loads never use prefetch cache
// - Non-cacheable never installs in P-cache, L2
// - Prefetch cache off: no prefetch, all miss
// - Enabled, no prefetch enables: lookup only
// - Hardware enable gates prefetch and FP fills
// - Software enable gates software prefetches
// - D-cache write-through, 4-way, 32-byte lines
`timescale 1ns/1ps
module ccfp_ctrl #(
  parameter int WAYS  = ccfp_pkg::DC_WAYS,   // D-cache associativity
  parameter int WORDS = ccfp_pkg::BLK_WORDS  // Commit block beats
) (
  // Clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  // Pipeline access decode
  input  wire ccfp_pkg::ccfp_acc_t   acc,
  output ccfp_pkg::ccfp_dec_t        dec_r,
  // FP register block data
  input  wire logic                  fp_wr_valid,
  input  wire logic [3:0]            fp_wr_idx,
  input  wire logic [31:0]           fp_wr_data,
  // Commit block store request
  input  wire logic                  cb_valid,
  input  wire logic [31:0]           cb_pa,
  output logic                       cb_ready,
  // Synchronising barrier
  input  wire logic                  membar_req,
  output logic                       membar_done,
  // L2 fill displacement
  input  wire ccfp_pkg::ccfp_fill_t  fill,
  output logic                       fill_ready,
  // Maintenance to cache arrays
  output logic                       maint_valid,
  output ccfp_pkg::ccfp_maint_t      maint_r,
  input  wire logic                  maint_ready,
  // Memory write port
  output logic                       mem_wr_valid,
  output logic [31:0]                mem_wr_addr_r,
  output logic [31:0]                mem_wr_data,
  output logic                       mem_wr_last,
  input  wire logic                  mem_wr_ready
);

  // Refuse geometries the sequencer does not serve
  if (WAYS != ccfp_pkg::DC_WAYS || WORDS != ccfp_pkg::BLK_WORDS) begin : g_chk
    $error("ccfp_ctrl supports only the documented geometry");
  end

  // Cacheability and prefetch-cache gating decode
  function automatic ccfp_pkg::ccfp_dec_t decode(input ccfp_pkg::ccfp_acc_t a,
                                                 input logic [2:0] en);
    ccfp_pkg::ccfp_dec_t d;
    logic pe;
    logic pc_ok;
    d  = '0;
    pe = en[ccfp_pkg::BIT_PCACHE_EN];
    d.valid     = a.valid;
    d.dc_use    = a.phys_cacheable_bit & a.virt_cacheable_bit & ~a.phys_use_l2;
    d.dc_bypass = ~d.dc_use;
    d.l2_alloc  = (a.phys_cacheable_bit | a.phys_use_l2) & ~a.block_load;
    pc_ok       = a.virt_cacheable_bit & ~a.block_load;
    d.pc_lookup  = pe & a.fp_load & pc_ok;
    d.pc_fp_fill = d.pc_lookup & en[ccfp_pkg::BIT_HW_PF_EN];
    d.hw_pf_ok   = pe & en[ccfp_pkg::BIT_HW_PF_EN] & pc_ok;
    d.sw_pf_go   = pe & en[ccfp_pkg::BIT_SW_PF_EN] & a.sw_prefetch & pc_ok;
    return d;
  endfunction

  // D-cache set index from VA colour bit and PA bits
  function automatic logic [ccfp_pkg::DC_IDX_W-1:0] dc_index(input logic va13,
                                                            input logic [31:0] pa);
    return {va13, pa[ccfp_pkg::DC_PA_IDX_HI:ccfp_pkg::DC_PA_IDX_LO]};
  endfunction

  // Register state
  logic [2:0]  dispatch_control_reg_r; // Prefetch enables
  logic [31:0] maint_pa_r;             // Software maintenance address
  logic        undef_r;                // Sticky undefined-hit flag
  ccfp_pkg::ccfp_state_t state_r;      // Sequencer state
  ccfp_pkg::ccfp_state_t state_nxt;    // Next sequencer state
  logic        va13_r;                 // Second D-cache index pending
  logic [3:0]  beat_r;                 // Commit beat counter
  logic [3:0]  raddr;                  // Buffer read address
  logic [31:0] cb_pa_r;                // Commit block address

  // APB decode
  logic apb_acc;   // Access phase
  logic apb_wr;    // Write in access phase
  logic hit_ctrl;  // Control register
  logic hit_pa;    // Address register
  logic hit_cmd;   // Command register
  logic hit_st;    // Status register
  logic cmd_ok;    // Command accepted
  logic idle;      // Sequencer idle
  logic mem_fire;  // Memory beat taken
  logic fill_take; // Displacement eviction taken

  assign apb_acc  = psel & penable;
  assign apb_wr   = apb_acc & pwrite;
  assign hit_ctrl = paddr == ccfp_pkg::OFS_DISPATCH_CTRL;
  assign hit_pa   = paddr == ccfp_pkg::OFS_MAINT_PA;
  assign hit_cmd  = paddr == ccfp_pkg::OFS_MAINT_CMD;
  assign hit_st   = paddr == ccfp_pkg::OFS_STATUS;
  assign idle     = state_r == ccfp_pkg::ST_IDLE;
  // Commands accepted only when idle and no commit or eviction competes
  assign cmd_ok   = idle & ~cb_valid & ~(fill.valid & fill.victim_dirty);
  assign pready   = 1'b1;
  // Unmapped address, or command while busy, is an error
  assign pslverr  = apb_acc & (~(hit_ctrl | hit_pa | hit_cmd | hit_st) |
                               (pwrite & hit_cmd & ~cmd_ok));

  // Read data mux
  always_comb begin
    prdata = '0;
    if (apb_acc & ~pwrite) begin
      if (hit_ctrl) begin
        prdata[2:0] = dispatch_control_reg_r;
      end else if (hit_pa) begin
        prdata = maint_pa_r;
      end else if (hit_st) begin
        prdata[ccfp_pkg::BIT_ST_BUSY]   = ~idle;
        prdata[ccfp_pkg::BIT_ST_UNSUP]  = &dispatch_control_reg_r;
        prdata[ccfp_pkg::BIT_ST_UNDEF]  = undef_r;
        prdata[ccfp_pkg::BIT_ST_CBPEND] = ~cb_ready;
      end
    end
  end

  // Prefetch enable register; all-ones combination reported, not blocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dispatch_control_reg_r <= ccfp_pkg::RST_DISPATCH;
    end else if (apb_wr & hit_ctrl) begin
      dispatch_control_reg_r <= pwdata[2:0];
    end
  end

  // Maintenance address register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maint_pa_r <= '0;
    end else if (apb_wr & hit_pa) begin
      maint_pa_r <= pwdata;
    end
  end

  // Sticky undefined-hit flag, set wins over write-one-to-clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      undef_r <= 1'b0;
    end else if (acc.valid & acc.phys_use_l2 & acc.dc_hit) begin
      undef_r <= 1'b1;
    end else if (apb_wr & hit_st & pwdata[ccfp_pkg::BIT_ST_UNDEF]) begin
      undef_r <= 1'b0;
    end
  end

  // Registered access decisions
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_r <= '0;
    end else begin
      dec_r <= decode(acc, dispatch_control_reg_r);
    end
  end

  // Handshakes to pipeline and caches
  assign cb_ready     = idle;
  assign fill_ready   = idle & ~cb_valid;
  assign fill_take    = fill_ready & fill.valid & fill.victim_dirty;
  assign membar_done  = membar_req & idle & ~cb_valid;
  assign maint_valid  = (state_r == ccfp_pkg::ST_DINV) | (state_r == ccfp_pkg::ST_L2FL) |
                        (state_r == ccfp_pkg::ST_L2DG) | (state_r == ccfp_pkg::ST_CBINV);
  assign mem_wr_valid = state_r == ccfp_pkg::ST_CBWR;
  assign mem_fire     = mem_wr_valid & mem_wr_ready;
  assign mem_wr_last  = mem_wr_valid & (beat_r == 4'(WORDS - 1));

  // Sequencer next state; commit store has priority over eviction and software
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ccfp_pkg::ST_IDLE: begin
        if (cb_valid) begin
          state_nxt = ccfp_pkg::ST_CBRD;
        end else if (fill.valid & fill.victim_dirty) begin
          state_nxt = ccfp_pkg::ST_L2FL;
        end else if (apb_wr & hit_cmd) begin
          case (ccfp_pkg::ccfp_op_t'(pwdata[1:0]))
            ccfp_pkg::MCMD_DC_PA_INV: state_nxt = ccfp_pkg::ST_DINV;
            ccfp_pkg::MCMD_L2_FLUSH:  state_nxt = ccfp_pkg::ST_L2FL;
            ccfp_pkg::MCMD_L2_DIAG:   state_nxt = ccfp_pkg::ST_L2DG;
            default:                  state_nxt = ccfp_pkg::ST_CBINV;
          endcase
        end
      end
      ccfp_pkg::ST_DINV: begin
        // Second index done ends the sequence
        if (maint_ready & va13_r) begin
          state_nxt = ccfp_pkg::ST_IDLE;
        end
      end
      ccfp_pkg::ST_L2FL,
      ccfp_pkg::ST_L2DG,
      ccfp_pkg::ST_CBINV: begin
        if (maint_ready) begin
          state_nxt = ccfp_pkg::ST_IDLE;
        end
      end
      ccfp_pkg::ST_CBRD: begin
        state_nxt = ccfp_pkg::ST_CBWR;
      end
      ccfp_pkg::ST_CBWR: begin
        if (mem_fire & mem_wr_last) begin
          state_nxt = ccfp_pkg::ST_CBINV;
        end
      end
      default: begin
        state_nxt = ccfp_pkg::ST_IDLE;
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ccfp_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // D-cache colour bit walks 0 then 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      va13_r <= 1'b0;
    end else if (state_r == ccfp_pkg::ST_DINV && maint_ready) begin
      va13_r <= ~va13_r;
    end
  end

  // Maintenance request contents
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maint_r <= '0;
    end else if (idle) begin
      maint_r.way_mask <= '1;
      maint_r.dc_idx   <= dc_index(1'b0, maint_pa_r);
      if (cb_valid) begin
        // All caches lose the block, nothing written back
        maint_r.op     <= ccfp_pkg::MCMD_INV_ALL;
        maint_r.pa     <= cb_pa;
        maint_r.wb     <= 1'b0;
        maint_r.wc_too <= 1'b1;
      end else if (fill.valid & fill.victim_dirty) begin
        // Displaced modified line is written back
        maint_r.op     <= ccfp_pkg::MCMD_L2_FLUSH;
        maint_r.pa     <= fill.victim_pa;
        maint_r.wb     <= 1'b1;
        maint_r.wc_too <= 1'b1;
      end else begin
        maint_r.op     <= ccfp_pkg::ccfp_op_t'(pwdata[1:0]);
        maint_r.pa     <= maint_pa_r;
        // Only L2 flush writes back; invalidates just clear
        maint_r.wb     <= pwdata[1:0] == ccfp_pkg::MCMD_L2_FLUSH;
        maint_r.wc_too <= pwdata[1:0] != ccfp_pkg::MCMD_DC_PA_INV;
      end
    end else if (state_r == ccfp_pkg::ST_DINV && maint_ready) begin
      maint_r.dc_idx <= dc_index(1'b1, maint_r.pa);
    end
  end

  // Commit address and beat counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_pa_r <= '0;
      beat_r  <= '0;
    end else if (idle) begin
      cb_pa_r <= cb_pa;
      beat_r  <= '0;
    end else if (mem_fire) begin
      beat_r  <= beat_r + 4'h1;
    end
  end

  // Memory address per beat, block aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_wr_addr_r <= '0;
    end else begin
      mem_wr_addr_r <= {cb_pa_r[31:ccfp_pkg::BLK_OFS_W], raddr, 2'h0};
    end
  end

  // Read next word ahead so data stays aligned with the beat
  assign raddr = mem_fire ? beat_r + 4'h1 : beat_r;

  // Block data buffer
  ccfp_blk_buf #(
    .WORDS (WORDS),
    .AW    (4)
  ) u_buf (
    .pclk    (pclk),
    .we      (fp_wr_valid),
    .waddr   (fp_wr_idx),
    .wdata   (fp_wr_data),
    .raddr   (raddr),
    .rdata_r (mem_wr_data)
  );

  // Assertions
  property p_dinv_two;
    @(posedge pclk) disable iff (!presetn)
      (state_r == ccfp_pkg::ST_DINV && maint_ready && !va13_r) |=>
        (state_r == ccfp_pkg::ST_DINV && maint_r.dc_idx[ccfp_pkg::DC_IDX_W-1]);
  endproperty
  a_dinv_two: assert property (p_dinv_two) else $error("second index missing");

  property p_ways;
    @(posedge pclk) disable iff (!presetn)
      maint_valid |-> maint_r.way_mask == '1;
  endproperty
  a_ways: assert property (p_ways) else $error("not all ways updated");

  property p_l2_wb;
    @(posedge pclk) disable iff (!presetn)
      (maint_valid && maint_r.op == ccfp_pkg::MCMD_L2_FLUSH) |-> maint_r.wb && maint_r.wc_too;
  endproperty
  a_l2_wb: assert property (p_l2_wb) else $error("L2 flush lacks writeback");

  property p_diag;
    @(posedge pclk) disable iff (!presetn)
      (state_r == ccfp_pkg::ST_L2DG) |-> !maint_r.wb;
  endproperty
  a_diag: assert property (p_diag) else $error("diag invalidate wrote back");

  property p_cb_inv;
    @(posedge pclk) disable iff (!presetn)
      (mem_fire && mem_wr_last) |=> (state_r == ccfp_pkg::ST_CBINV &&
                                     maint_r.op == ccfp_pkg::MCMD_INV_ALL);
  endproperty
  a_cb_inv: assert property (p_cb_inv) else $error("commit did not invalidate");

  property p_membar;
    @(posedge pclk) disable iff (!presetn)
      membar_done |-> idle;
  endproperty
  a_membar: assert property (p_membar) else $error("barrier passed commit");

  property p_pc_off;
    @(posedge pclk) disable iff (!presetn)
      !$past(dispatch_control_reg_r[ccfp_pkg::BIT_PCACHE_EN]) |->
        !(dec_r.pc_lookup | dec_r.pc_fp_fill | dec_r.sw_pf_go | dec_r.hw_pf_ok);
  endproperty
  a_pc_off: assert property (p_pc_off) else $error("prefetch cache active when off");

  property p_blk;
    @(posedge pclk) disable iff (!presetn)
      $past(acc.block_load) |-> !(dec_r.pc_lookup | dec_r.hw_pf_ok | dec_r.l2_alloc);
  endproperty
  a_blk: assert property (p_blk) else $error("block load used prefetch cache");

  property p_nc;
    @(posedge pclk) disable iff (!presetn)
      $past(acc.valid && !acc.phys_cacheable_bit && !acc.virt_cacheable_bit &&
            !acc.phys_use_l2) |-> !(dec_r.l2_alloc | dec_r.pc_lookup | dec_r.pc_fp_fill);
  endproperty
  a_nc: assert property (p_nc) else $error("non-cacheable installed");

  property p_hpe;
    @(posedge pclk) disable iff (!presetn)
      dec_r.pc_fp_fill |-> $past(dispatch_control_reg_r[ccfp_pkg::BIT_HW_PF_EN]);
  endproperty
  a_hpe: assert property (p_hpe) else $error("FP fill without hw enable");

  property p_cb_len;
    @(posedge pclk) disable iff (!presetn)
      (state_r == ccfp_pkg::ST_CBRD) |=> (mem_wr_valid && beat_r == 4'h0);
  endproperty
  a_cb_len: assert property (p_cb_len) else $error("commit beats misaligned");

  // Main scenarios
  c_commit: cover property (@(posedge pclk) disable iff (!presetn)
                            state_r == ccfp_pkg::ST_CBINV && maint_ready);
  c_dinv:   cover property (@(posedge pclk) disable iff (!presetn)
                            state_r == ccfp_pkg::ST_DINV && va13_r && maint_ready);
  c_disp:   cover property (@(posedge pclk) disable iff (!presetn) fill_take);
  c_swpf:   cover property (@(posedge pclk) disable iff (!presetn) dec_r.sw_pf_go);

endmodule

// >>> verification/ccfp_far_model.sv
/* Far-side model: cache arrays and memory write port answering the block.
   Assumes it shares pclk and presetn with the block. */
`timescale 1ns/1ps
module ccfp_far_model (
  // Clock, reset, pacing
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic slow,
  // Handshakes
  input  wire logic maint_valid,
  input  wire logic mem_wr_valid,
  output logic      maint_ready,
  output logic      mem_wr_ready
);
  logic [2:0] ph_r; // Memory stall phase
  logic [2:0] wt_r; // Maintenance wait count
  // Free-running phase that paces slow memory beats
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ph_r <= 3'h0;
    else ph_r <= ph_r + 3'h1;
  end
  // Slow arrays answer on the eighth cycle of each request, so busy stays visible
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wt_r <= 3'h0;
    else if (!maint_valid || maint_ready) wt_r <= 3'h0;
    else wt_r <= wt_r + 3'h1;
  end
  // Arrays accept maintenance at once, or on the eighth cycle when slow
  assign maint_ready  = maint_valid & (~slow | (wt_r == 3'h7));
  // Memory takes each commit beat
  assign mem_wr_ready = mem_wr_valid & (~slow | ph_r[0]);
endmodule

// >>> verification/ccfp_ctrl_bench.sv
/* Self-checking bench for the flush sequencer and prefetch gating.
   Assumes the far-side model answers maintenance and memory beats. */
`timescale 1ns/1ps
module ccfp_ctrl_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, cb_pa = 32'h0, r, pa, mem_wr_addr_r, mem_wr_data;
  logic pready, pslverr, e, cb_ready, membar_done, fill_ready, maint_valid, maint_ready;
  logic fp_wr_valid = 0, cb_valid = 0, membar_req = 0, mem_wr_valid, mem_wr_last, mem_wr_ready;
  logic [3:0] fp_wr_idx = 4'h0;
  logic [31:0] fp_wr_data = 32'h0, buf_q [16];
  logic [2:0] en;
  ccfp_pkg::ccfp_acc_t acc = '0;
  ccfp_pkg::ccfp_dec_t dec_r;
  ccfp_pkg::ccfp_fill_t fill = '0;
  ccfp_pkg::ccfp_maint_t maint_r;
  int error_cnt = 0, n_tests = 0, cyc = 0, k;
  always #25 pclk = ~pclk; // 20 MHz
  ccfp_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .acc(acc), .dec_r(dec_r), .fp_wr_valid(fp_wr_valid),
    .fp_wr_idx(fp_wr_idx), .fp_wr_data(fp_wr_data), .cb_valid(cb_valid), .cb_pa(cb_pa),
    .cb_ready(cb_ready), .membar_req(membar_req), .membar_done(membar_done), .fill(fill),
    .fill_ready(fill_ready), .maint_valid(maint_valid), .maint_r(maint_r),
    .maint_ready(maint_ready), .mem_wr_valid(mem_wr_valid), .mem_wr_addr_r(mem_wr_addr_r),
    .mem_wr_data(mem_wr_data), .mem_wr_last(mem_wr_last), .mem_wr_ready(mem_wr_ready));
  ccfp_far_model FAR (.pclk(pclk), .presetn(presetn), .slow(slow), .maint_valid(maint_valid),
    .mem_wr_valid(mem_wr_valid), .maint_ready(maint_ready), .mem_wr_ready(mem_wr_ready));
  // Compare and count
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_tests++;
    if (got !== ex) begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      error_cnt++;
    end
  endtask
  // One APB transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; end
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // Wait for one maintenance handshake and check it
  task mwait(input logic [1:0] op, input logic [31:0] p, input logic [8:0] ix, input logic wb);
    do @(negedge pclk); while (!(maint_valid === 1'b1 && maint_ready === 1'b1));
    chk("op", op, maint_r.op);
    chk("pa", p, maint_r.pa);
    chk("wb", wb, maint_r.wb);
    if (op != 2'h0) chk("wc", 1, maint_r.wc_too);
    else chk("idx", ix, maint_r.dc_idx);
    if (op == 2'h0) chk("ways", 32'hF, maint_r.way_mask);
  endtask
  // Expected decode
  function automatic ccfp_pkg::ccfp_dec_t exd(ccfp_pkg::ccfp_acc_t a, logic [2:0] c);
    ccfp_pkg::ccfp_dec_t d;
    logic v;
    v = a.virt_cacheable_bit & ~a.block_load;
    d.valid = a.valid;
    d.dc_use = a.phys_cacheable_bit & a.virt_cacheable_bit & ~a.phys_use_l2;
    d.dc_bypass = ~d.dc_use;
    d.l2_alloc = (a.phys_cacheable_bit | a.phys_use_l2) & ~a.block_load;
    d.pc_lookup = c[0] & a.fp_load & v;
    d.pc_fp_fill = d.pc_lookup & c[1];
    d.sw_pf_go = c[0] & c[2] & a.sw_prefetch & v;
    d.hw_pf_ok = c[0] & c[1] & v;
    return d;
  endfunction
  // Verdict
  task close_out;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin error_cnt++; close_out; end
  end
  initial begin
    void'($urandom(84));
    repeat (12) @(posedge pclk);
    presetn <= 1;
    apb(0, ccfp_pkg::OFS_DISPATCH_CTRL, 0); chk("ctrl rst", 0, r);
    apb(0, 12'h010, 0); chk("unmapped", 1, e);
    // Random decode across all enable settings
    for (int i = 0; i < 64; i++) begin
      if (i % 8 == 0) begin
        en = 3'(i / 8);
        apb(1, ccfp_pkg::OFS_DISPATCH_CTRL, {29'h0, en});
        apb(0, ccfp_pkg::OFS_STATUS, 0);
        chk("status", {30'h0, &en, 1'b0}, r);
      end
      @(posedge pclk) acc <= ccfp_pkg::ccfp_acc_t'({1'b1, 7'($urandom) & 7'h7E});
      @(posedge pclk);
      @(negedge pclk) chk("dec", exd(acc, en), dec_r);
    end
    apb(1, ccfp_pkg::OFS_DISPATCH_CTRL, 0);
    // Every maintenance op, slow arrays, refusal while busy
    slow <= 1;
    for (int op = 0; op < 4; op++) begin
      pa = $urandom;
      apb(1, ccfp_pkg::OFS_MAINT_PA, pa);
      apb(1, ccfp_pkg::OFS_MAINT_CMD, op);
      apb(1, ccfp_pkg::OFS_MAINT_CMD, op); chk("busy refuse", 1, e);
      apb(0, ccfp_pkg::OFS_STATUS, 0);
      chk("status busy", 32'h9, r);
      mwait(2'(op), pa, {1'b0, pa[12:5]}, op == 1);
      if (op == 0) mwait(0, pa, {1'b1, pa[12:5]}, 0);
    end
    // Displacement of a dirty victim
    pa = $urandom;
    @(posedge pclk) fill <= '{1'b1, 1'b1, pa};
    @(negedge pclk) chk("fill_ready", 1, fill_ready);
    @(posedge pclk) fill <= '0;
    mwait(1, pa, 0, 1);
    // Commit block store, barrier held meanwhile
    for (k = 0; k < 16; k++) begin
      buf_q[k] = $urandom;
      @(posedge pclk) begin fp_wr_valid <= 1; fp_wr_idx <= 4'(k); fp_wr_data <= buf_q[k]; end
    end
    pa = $urandom;
    @(posedge pclk) begin fp_wr_valid <= 0; cb_valid <= 1; cb_pa <= pa; membar_req <= 1; end
    @(negedge pclk) chk("cb_ready", 1, cb_ready);
    @(posedge pclk) cb_valid <= 0;
    k = 0;
    while (k < 16) begin
      @(negedge pclk) chk("membar", 0, membar_done);
      if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1) begin
        chk("addr", {pa[31:6], 4'(k), 2'b00}, mem_wr_addr_r);
        chk("data", buf_q[k], mem_wr_data);
        chk("last", k == 15, mem_wr_last);
        k++;
      end
    end
    mwait(3, pa, 0, 0);
    @(negedge pclk) chk("membar end", 1, membar_done);
    close_out;
  end
endmodule
